/* File: rtl/bit_shift_flag_datapath.sv */
`timescale 1ns/10ps
`default_nettype none

module bit_shift_flag_datapath
    import bsf_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        ce_i,
    // Decoder side.
    input  wire logic        op_valid_i,
    input  wire logic [4:0]  op_code_i,
    input  wire logic [7:0]  op_operand_i,
    input  wire logic [2:0]  op_bit_i,
    output logic      [7:0]  result_o,
    output logic             result_valid_o,
    output logic      [7:0]  status_flags_o,
    // AXI4-Lite slave.
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    logic [7:0]  status_flags_reg;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        cmd_pending;
    logic [4:0]  cmd_op;
    logic [2:0]  cmd_bit;
    logic [7:0]  cmd_data;
    logic [31:0] op_count;
    logic        exec_go;
    logic        exec_from_cmd;
    op_t         exec_op;
    logic [7:0]  exec_data;
    logic [2:0]  exec_bit;
    logic [7:0]  next_result;
    logic        next_writes_reg;
    logic [7:0]  next_flags;
    logic        bus_write;
    logic        bus_write_cmd;
    logic        bus_write_flags;

    // -----------------------------------------------------------------
    // Operation select.
    // -----------------------------------------------------------------

    // The decoder has priority; a bus command waits while it is busy,
    // so a software-issued operation is delayed, and lost only if a second command write replaces it.
    always_comb begin
        exec_from_cmd = cmd_pending && !op_valid_i;
        exec_go       = ce_i && (op_valid_i || cmd_pending);
        exec_op       = op_t'(exec_from_cmd ? cmd_op : op_code_i);
        exec_data     = exec_from_cmd ? cmd_data : op_operand_i;
        exec_bit      = exec_from_cmd ? cmd_bit : op_bit_i;
    end

    bit_op_unit u_bit_op_unit (
        .op_i         (exec_op),
        .data_i       (exec_data),
        .bit_i        (exec_bit),
        .flags_i      (status_flags_reg),
        .result_o     (next_result),
        .writes_reg_o (next_writes_reg),
        .flags_o      (next_flags)
    );

    // -----------------------------------------------------------------
    // Status register and result.
    // -----------------------------------------------------------------

    // Flags settle at the edge that executes the operation, so the next
    // instruction already sees them. An operation in the same cycle as a
    // bus write to the flags wins, since it is the later program event.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_flags_reg <= FLAGS_RESET;
        end else if (ce_i) begin
            if (exec_go) begin
                status_flags_reg <= next_flags;
            end else if (bus_write_flags) begin
                status_flags_reg <= w_data[7:0];
            end
        end
    end

    assign status_flags_o = status_flags_reg;

    // Result register presents the write-back value for one cycle.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_o       <= 8'h00;
            result_valid_o <= 1'b0;
        end else if (ce_i) begin
            result_valid_o <= exec_go && next_writes_reg;
            if (exec_go && next_writes_reg) begin
                result_o <= next_result;
            end
        end
    end

    // Count of executed operations, visible to software.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            op_count <= 32'h0000_0000;
        end else if (ce_i && exec_go) begin
            op_count <= op_count + 32'h0000_0001;
        end
    end

    // -----------------------------------------------------------------
    // AXI4-Lite write channel.
    // -----------------------------------------------------------------

    // Address and data are each taken once; the write happens when both
    // are held and no response is outstanding.
    assign bus_write       = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign bus_write_flags = bus_write && (aw_addr == ADDR_FLAGS) && w_strb[0];
    assign bus_write_cmd   = bus_write && (aw_addr == ADDR_COMMAND);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end else if (ce_i) begin
            if (s_axi_awready && s_axi_awvalid) begin
                s_axi_awready <= 1'b0;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                s_axi_wready <= 1'b0;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (bus_write) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr == ADDR_FLAGS || aw_addr == ADDR_COMMAND) begin
                    s_axi_bresp <= RESP_OKAY;
                end else if (aw_addr == ADDR_RESULT || aw_addr == ADDR_COUNT) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // A command write queues one operation; a second command while one
    // is still waiting replaces it.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_pending <= 1'b0;
            cmd_op      <= 5'h00;
            cmd_bit     <= 3'h0;
            cmd_data    <= 8'h00;
        end else if (ce_i) begin
            if (bus_write_cmd) begin
                cmd_pending <= 1'b1;
                cmd_op      <= w_data[CMD_OP_LSB +: 5];
                cmd_bit     <= w_data[CMD_BIT_LSB +: 3];
                cmd_data    <= w_data[CMD_DATA_LSB +: 8];
            end else if (exec_from_cmd) begin
                cmd_pending <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // AXI4-Lite read channel.
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                if (s_axi_araddr == ADDR_FLAGS) begin
                    s_axi_rdata <= {24'h000000, status_flags_reg};
                end else if (s_axi_araddr == ADDR_RESULT) begin
                    s_axi_rdata <= {24'h000000, result_o};
                end else if (s_axi_araddr == ADDR_COMMAND) begin
                    s_axi_rdata <= {31'h0000_0000, cmd_pending};
                end else if (s_axi_araddr == ADDR_COUNT) begin
                    s_axi_rdata <= op_count;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Assertions.
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_fire(op_t o);
        exec_go && exec_op == o;
    endsequence

    a_rotate_left_result: assert property (
        s_fire(rotate_left_carry_op) |=>
            result_o == {$past(exec_data[6:0]), $past(status_flags_reg[FLAG_C])}
            && status_flags_reg[FLAG_C] == $past(exec_data[7])
            && status_flags_reg[FLAG_N] == result_o[7])
        else $error("Rotate left result or flags wrong.");

    a_rotate_right_result: assert property (
        s_fire(rotate_right_carry_op) |=>
            result_o == {$past(status_flags_reg[FLAG_C]), $past(exec_data[7:1])}
            && status_flags_reg[FLAG_C] == $past(exec_data[0])
            && status_flags_reg[FLAG_Z] == (result_o == 8'h00))
        else $error("Rotate right result or flags wrong.");

    a_arith_shift_result: assert property (
        s_fire(arith_shift_right_op) |=>
            result_o == {$past(exec_data[7]), $past(exec_data[7:1])}
            && status_flags_reg[FLAG_V] ==
               (status_flags_reg[FLAG_N] ^ status_flags_reg[FLAG_C]))
        else $error("Arithmetic shift result or flags wrong.");

    a_swap_keeps_flags: assert property (
        s_fire(nibble_swap_op) |=>
            result_o == {$past(exec_data[3:0]), $past(exec_data[7:4])}
            && $stable(status_flags_reg))
        else $error("Nibble swap wrong or flags changed.");

    a_generic_set_bit: assert property (
        s_fire(generic_flag_set_op) |=>
            status_flags_reg ==
            ($past(status_flags_reg) | (8'h01 << $past(exec_bit))))
        else $error("Generic set touched the wrong flag.");

    a_generic_clear_bit: assert property (
        s_fire(generic_flag_clear_op) |=>
            status_flags_reg ==
            ($past(status_flags_reg) & ~(8'h01 << $past(exec_bit))))
        else $error("Generic clear touched the wrong flag.");

    a_bit_store_t: assert property (
        s_fire(bit_to_transfer_op) |=>
            status_flags_reg[FLAG_T] == $past(exec_data[exec_bit])
            && status_flags_reg[5:0] == $past(status_flags_reg[5:0]))
        else $error("Bit store did not copy into T alone.");

    a_bit_load_reg: assert property (
        s_fire(transfer_to_bit_op) |=>
            result_o[$past(exec_bit)] == $past(status_flags_reg[FLAG_T])
            && $stable(status_flags_reg) && result_valid_o)
        else $error("Bit load result wrong or flags changed.");

    a_carry_set_clear: assert property (
        s_fire(carry_set_op) or s_fire(carry_clear_op) |=>
            status_flags_reg[FLAG_C] == $past(exec_op == carry_set_op)
            && status_flags_reg[7:1] == $past(status_flags_reg[7:1]))
        else $error("Carry set or clear wrong.");

    a_negative_set_clear: assert property (
        s_fire(negative_set_op) or s_fire(negative_clear_op) |=>
            status_flags_reg[FLAG_N] == $past(exec_op == negative_set_op))
        else $error("Negative set or clear wrong.");

    a_zero_set_clear: assert property (
        s_fire(zero_set_op) or s_fire(zero_clear_op) |=>
            status_flags_reg[FLAG_Z] == $past(exec_op == zero_set_op))
        else $error("Zero set or clear wrong.");

    a_irq_enable_flag: assert property (
        s_fire(irq_enable_op) |=> status_flags_reg[FLAG_I])
        else $error("Interrupt enable did not set I.");

    a_irq_disable_flag: assert property (
        s_fire(irq_disable_op) |=> !status_flags_reg[FLAG_I])
        else $error("Interrupt disable did not clear I.");

    a_sign_set_flag: assert property (
        s_fire(sign_set_op) |=> status_flags_reg[FLAG_S]
            && status_flags_reg[3:0] == $past(status_flags_reg[3:0]))
        else $error("Sign set wrong.");

    a_overflow_set_clear: assert property (
        s_fire(overflow_set_op) or s_fire(overflow_clear_op) |=>
            status_flags_reg[FLAG_V] == $past(exec_op == overflow_set_op))
        else $error("Overflow set or clear wrong.");

    a_transfer_set_flag: assert property (
        s_fire(transfer_set_op) |=> status_flags_reg[FLAG_T]
            && status_flags_reg[5:0] == $past(status_flags_reg[5:0]))
        else $error("Transfer set wrong.");

    a_single_cycle_result: assert property (
        exec_go && next_writes_reg |=> result_valid_o ##1
            (!result_valid_o || $past(exec_go && next_writes_reg) || !$past(ce_i)))
        else $error("Result not presented in one cycle.");

    a_clear_sign_transfer: assert property (
        s_fire(sign_clear_op) or s_fire(transfer_clear_op) |=>
            ($past(exec_op == sign_clear_op) ? !status_flags_reg[FLAG_S]
                                               : !status_flags_reg[FLAG_T]))
        else $error("Sign or transfer clear wrong.");

    a_flag_bit_order: assert property (
        exec_go && exec_op == generic_flag_set_op && exec_bit == 3'h7
            |=> status_flags_reg[FLAG_I])
        else $error("Index 7 did not select the interrupt flag.");

endmodule

`default_nettype wire

/* File: rtl/bsf_pkg.sv */
package bsf_pkg;

    // -----------------------------------------------------------------
    // Status register bit positions.
    // -----------------------------------------------------------------
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;

    // -----------------------------------------------------------------
    // Register map on the AXI4-Lite bus.
    // -----------------------------------------------------------------
    localparam logic [3:0]  ADDR_FLAGS   = 4'h0;
    localparam logic [3:0]  ADDR_RESULT  = 4'h4;
    localparam logic [3:0]  ADDR_COMMAND = 4'h8;
    localparam logic [3:0]  ADDR_COUNT   = 4'hC;
    localparam int unsigned CMD_OP_LSB   = 0;
    localparam int unsigned CMD_BIT_LSB  = 8;
    localparam int unsigned CMD_DATA_LSB = 16;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // -----------------------------------------------------------------
    // Operation codes.
    // -----------------------------------------------------------------
    typedef enum logic [4:0] {
        no_op                 = 5'h00,
        rotate_left_carry_op  = 5'h01,
        rotate_right_carry_op = 5'h02,
        arith_shift_right_op  = 5'h03,
        nibble_swap_op        = 5'h04,
        generic_flag_set_op   = 5'h05,
        generic_flag_clear_op = 5'h06,
        bit_to_transfer_op    = 5'h07,
        transfer_to_bit_op    = 5'h08,
        carry_set_op          = 5'h09,
        carry_clear_op        = 5'h0A,
        negative_set_op       = 5'h0B,
        negative_clear_op     = 5'h0C,
        zero_set_op           = 5'h0D,
        zero_clear_op         = 5'h0E,
        irq_enable_op         = 5'h0F,
        irq_disable_op        = 5'h10,
        sign_set_op           = 5'h11,
        sign_clear_op         = 5'h12,
        overflow_set_op       = 5'h13,
        overflow_clear_op     = 5'h14,
        transfer_set_op       = 5'h15,
        transfer_clear_op     = 5'h16
    } op_t;

endpackage

/* File: rtl/bit_op_unit.sv */
`timescale 1ns/10ps
`default_nettype none

module bit_op_unit
    import bsf_pkg::*;
(
    input  wire op_t        op_i,
    input  wire logic [7:0] data_i,
    input  wire logic [2:0] bit_i,
    input  wire logic [7:0] flags_i,
    output logic      [7:0] result_o,
    output logic            writes_reg_o,
    output logic      [7:0] flags_o
);

    logic [7:0] shifted;
    logic       carry_out;

    // -----------------------------------------------------------------
    // Combinational result and next flags of one operation.
    // -----------------------------------------------------------------
    always_comb begin
        shifted      = data_i;
        carry_out    = data_i[0];
        result_o     = data_i;
        writes_reg_o = 1'b0;
        flags_o      = flags_i;
        case (op_i)
            rotate_left_carry_op: begin
                shifted   = {data_i[6:0], flags_i[FLAG_C]};
                carry_out = data_i[7];
            end
            rotate_right_carry_op: begin
                shifted = {flags_i[FLAG_C], data_i[7:1]};
            end
            arith_shift_right_op: begin
                shifted = {data_i[7], data_i[7:1]};
            end
            default: begin
                shifted = data_i;
            end
        endcase
        case (op_i)
            rotate_left_carry_op, rotate_right_carry_op, arith_shift_right_op: begin
                // Shift group updates Z, C, N and V; S and H stay put.
                result_o          = shifted;
                writes_reg_o      = 1'b1;
                flags_o[FLAG_C]   = carry_out;
                flags_o[FLAG_Z]   = (shifted == 8'h00);
                flags_o[FLAG_N]   = shifted[7];
                flags_o[FLAG_V]   = shifted[7] ^ carry_out;
            end
            nibble_swap_op: begin
                result_o     = {data_i[3:0], data_i[7:4]};
                writes_reg_o = 1'b1;
            end
            generic_flag_set_op:   flags_o[bit_i] = 1'b1;
            generic_flag_clear_op: flags_o[bit_i] = 1'b0;
            bit_to_transfer_op:    flags_o[FLAG_T] = data_i[bit_i];
            transfer_to_bit_op: begin
                result_o        = data_i;
                result_o[bit_i] = flags_i[FLAG_T];
                writes_reg_o    = 1'b1;
            end
            carry_set_op:      flags_o[FLAG_C] = 1'b1;
            carry_clear_op:    flags_o[FLAG_C] = 1'b0;
            negative_set_op:   flags_o[FLAG_N] = 1'b1;
            negative_clear_op: flags_o[FLAG_N] = 1'b0;
            zero_set_op:       flags_o[FLAG_Z] = 1'b1;
            zero_clear_op:     flags_o[FLAG_Z] = 1'b0;
            irq_enable_op:     flags_o[FLAG_I] = 1'b1;
            irq_disable_op:    flags_o[FLAG_I] = 1'b0;
            sign_set_op:       flags_o[FLAG_S] = 1'b1;
            sign_clear_op:     flags_o[FLAG_S] = 1'b0;
            overflow_set_op:   flags_o[FLAG_V] = 1'b1;
            overflow_clear_op: flags_o[FLAG_V] = 1'b0;
            transfer_set_op:   flags_o[FLAG_T] = 1'b1;
            transfer_clear_op: flags_o[FLAG_T] = 1'b0;
            default: begin
                flags_o = flags_i;
            end
        endcase
    end

endmodule

`default_nettype wire

/* File: testbench/decoder_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Decoder stand-in: the request on the _i lines reaches the datapath one edge later.
module decoder_model (
    input  wire logic       clk_i,
    input  wire logic       issue_i,
    input  wire logic [4:0] code_i,
    input  wire logic [7:0] data_i,
    input  wire logic [2:0] bit_i,
    output logic            op_valid_o,
    output logic      [4:0] op_code_o,
    output logic      [7:0] op_operand_o,
    output logic      [2:0] op_bit_o
);
    // Idle operand lines toggle, so a stale value never passes for a live one.
    always_ff @(posedge clk_i) begin
        op_valid_o   <= issue_i;
        op_code_o    <= code_i;
        op_bit_o     <= bit_i;
        op_operand_o <= issue_i ? data_i : ~op_operand_o;
    end
endmodule
`default_nettype wire

/* File: testbench/bit_shift_flag_datapath_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module bit_shift_flag_datapath_tb_top;
    import bsf_pkg::*;
    localparam int unsigned POS [7] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T};
    logic clk_i = 0, reset_n_i = 0, ce_i = 1, issue = 0;
    logic [4:0] code = 0;
    logic [7:0] data = 0, exp_f = FLAGS_RESET, exp_r = 0;
    logic [2:0] bsel = 0;
    wire logic op_valid_i, result_valid_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic [4:0] op_code_i;
    wire logic [7:0] op_operand_i, result_o, status_flags_o;
    wire logic [2:0] op_bit_i;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic s_axi_arready, s_axi_rvalid;
    wire logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    int error_cnt = 0, samples_checked = 0;
    logic [16:0] q [$];
    logic [16:0] e;
    logic [31:0] rd, cw;
    logic [1:0] rs;
    always #2.5 clk_i = ~clk_i;
    decoder_model u_dec (.clk_i, .issue_i(issue), .code_i(code), .data_i(data), .bit_i(bsel),
        .op_valid_o(op_valid_i), .op_code_o(op_code_i), .op_operand_o(op_operand_i),
        .op_bit_o(op_bit_i));
    bit_shift_flag_datapath DUT (.clk_i, .reset_n_i, .ce_i, .op_valid_i, .op_code_i,
        .op_operand_i, .op_bit_i, .result_o, .result_valid_o, .status_flags_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    // Reference: {writes register, result, flags} for one op on the given state.
    function automatic logic [16:0] predict(logic [4:0] c, logic [7:0] d, logic [2:0] b,
                                            logic [7:0] f);
        logic [7:0] r;
        logic [7:0] g;
        logic w;
        r = d; g = f; w = (c >= 1 && c <= 4) || c == 8;
        case (c)
            1: begin r = {d[6:0], f[FLAG_C]}; g[FLAG_C] = d[7]; end
            2: begin r = {f[FLAG_C], d[7:1]}; g[FLAG_C] = d[0]; end
            3: begin r = {d[7], d[7:1]}; g[FLAG_C] = d[0]; end
            4: r = {d[3:0], d[7:4]};
            5: g[b] = 1'b1;
            6: g[b] = 1'b0;
            7: g[FLAG_T] = d[b];
            8: r[b] = f[FLAG_T];
            default: if (c >= 9 && c <= 22) g[POS[(c - 9) / 2]] = c[0];
        endcase
        if (c >= 1 && c <= 3) begin
            g[FLAG_Z] = (r == 8'h00); g[FLAG_N] = r[7]; g[FLAG_V] = r[7] ^ g[FLAG_C];
        end
        return {w, r, g};
    endfunction
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Bus master: each channel is released only at the edge that takes it.
    task automatic axi(logic wr, logic [3:0] a, logic [31:0] d);
        int n;
        if (wr) begin
            s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        end
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if ((wr && s_axi_bvalid) || (!wr && s_axi_rvalid)) break;
        end
        rd = s_axi_rdata; rs = wr ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 0; s_axi_rready <= 0;
        if (n == 50) begin error_cnt++; tally_and_finish(); end
        // One idle edge keeps a release and the next raise out of one time step.
        @(posedge clk_i);
    endtask
    initial begin
        void'($urandom(84));
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1;
        @(posedge clk_i);
        for (int t = 0; t < 6; t++) begin
            // Back-to-back ops, each but the last two checked the cycle it lands; first batch walks every code.
            for (int i = 0; i < 42; i++) begin
                @(posedge clk_i);
                issue <= 1;
                code <= (i >= 40) ? 5'h00 : (t == 0 && i < 22) ? 5'(i + 1) : 5'($urandom_range(1, 22));
                data <= (i % 5 == 0) ? 8'h01 : 8'($urandom);
                bsel <= 3'($urandom);
                #1 e = predict(code, data, bsel, exp_f);
                exp_f = e[7:0];
                if (e[16]) exp_r = e[15:8];
                q.push_back(e);
                if (q.size() > 2) begin
                    e = q.pop_front();
                    chk("flags", e[7:0], status_flags_o);
                    chk("valid", e[16], result_valid_o);
                    if (e[16]) chk("result", e[15:8], result_o);
                end
            end
            @(posedge clk_i) issue <= 0;
            repeat (2) @(posedge clk_i);
            q.delete();
            // Clock enable low: an offered op must be ignored and all state frozen.
            ce_i <= 0; issue <= 1; code <= 5'($urandom_range(1, 22));
            repeat (4) @(posedge clk_i);
            chk("frozen_flags", exp_f, status_flags_o);
            chk("frozen_valid", 0, result_valid_o);
            issue <= 0;
            repeat (2) @(posedge clk_i);
            ce_i <= 1;
            axi(0, ADDR_RESULT, 0); chk("rd_result", exp_r, rd);
            exp_f = 8'($urandom);
            axi(1, ADDR_FLAGS, exp_f); chk("bresp", RESP_OKAY, rs);
            axi(0, ADDR_FLAGS, 0); chk("rd_flags", exp_f, rd);
            axi(0, 4'h2, 0); chk("rresp", RESP_SLVERR, rs);
            // A software command runs once the decoder is idle and is counted.
            cw = {8'h00, 8'($urandom), 5'h00, 3'($urandom), 3'h0, 5'($urandom_range(1, 22))};
            e = predict(cw[4:0], cw[23:16], cw[10:8], exp_f);
            exp_f = e[7:0];
            if (e[16]) exp_r = e[15:8];
            axi(1, ADDR_COMMAND, cw); chk("bresp_cmd", RESP_OKAY, rs);
            axi(0, ADDR_FLAGS, 0); chk("cmd_flags", exp_f, rd);
            axi(0, ADDR_COUNT, 0); chk("op_count", 43 * (t + 1), rd);
            $display("batch %0d done", t);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
